/* eiu_pkg.sv */
// constants shared by the external interrupt unit
// assumes a 32-bit apb slave with byte addresses on paddr
package eiu_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_EXT_FLAGS    = 8'h1C;
    localparam logic [7:0] OFS_EXT_ENABLE   = 8'h20;
    localparam logic [7:0] OFS_GROUP_FLAGS  = 8'h24;
    localparam logic [7:0] OFS_SENSE_CTRL   = 8'h64;
    localparam logic [7:0] OFS_GROUP_ENABLE = 8'h68;
    localparam logic [7:0] OFS_MASK_LOW     = 8'h70;
    localparam logic [7:0] OFS_MASK_MID     = 8'h74;
    localparam logic [7:0] OFS_MASK_HIGH    = 8'h78;

    // register widths in use; upper bits read zero
    localparam int EXT_W   = 2;
    localparam int GROUP_W = 3;
    localparam int SENSE_W = 4;
    localparam int MID_W   = 7;

    // reset values
    localparam logic [7:0] RST_REG = 8'h00;

    // field positions inside the sense control register
    localparam int SENSE_ONE_LO  = 2;
    localparam int SENSE_ZERO_LO = 0;

    typedef enum logic [1:0] {
        SENSE_LOW_LEVEL = 2'b00,
        SENSE_ANY_EDGE  = 2'b01,
        SENSE_FALLING   = 2'b10,
        SENSE_RISING    = 2'b11
    } eiu_sense_type;

endpackage

/* eiu_top.sv */
// external interrupt unit: two sensed pins and three pin-change groups
// assumes apb master on pclk, pins asynchronous, cpu handshake on pclk
`timescale 1ns/1ps

module eiu_top #(
    parameter int PC_W = 24
) (
    // apb clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // pins
    input  wire logic                 ext_irq_pin_zero,
    input  wire logic                 ext_irq_pin_one,
    input  wire logic [PC_W-1:0]      pin_change_inputs,
    // cpu side
    input  wire logic                 global_irq_enable,
    input  wire logic                 io_clock_running,
    input  wire logic [1:0]           ext_irq_serviced,
    input  wire logic [2:0]           group_irq_serviced,
    output logic      [1:0]           ext_irq_request,
    output logic      [2:0]           group_irq_request,
    output logic                      wake_request
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and previous samples

    logic [1:0]      ext_meta_q;
    logic [1:0]      ext_sync_q;
    logic [1:0]      ext_prev_q;
    logic [PC_W-1:0] pc_meta_q;
    logic [PC_W-1:0] pc_sync_q;
    logic [PC_W-1:0] pc_prev_q;

    // pins read whatever the pad sees, driven or not
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_meta_q <= '0;
            ext_sync_q <= '0;
            ext_prev_q <= '0;
        end else begin
            ext_meta_q <= {ext_irq_pin_one, ext_irq_pin_zero};
            ext_sync_q <= ext_meta_q;
            ext_prev_q <= ext_sync_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_meta_q <= '0;
            pc_sync_q <= '0;
            pc_prev_q <= '0;
        end else begin
            pc_meta_q <= pin_change_inputs;
            pc_sync_q <= pc_meta_q;
            pc_prev_q <= pc_sync_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    logic [eiu_pkg::EXT_W-1:0]   ext_flag_q;
    logic [eiu_pkg::EXT_W-1:0]   ext_enable_q;
    logic [eiu_pkg::GROUP_W-1:0] group_flag_q;
    logic [eiu_pkg::GROUP_W-1:0] group_enable_q;
    logic [eiu_pkg::SENSE_W-1:0] sense_q;
    logic [7:0]                  pin_mask_low_q;
    logic [eiu_pkg::MID_W-1:0]   pin_mask_mid_q;
    logic [7:0]                  pin_mask_high_q;

    logic                        wr_fire;
    logic [7:0]                  wbyte;

    // writes take effect only at the completing edge; read data is latched one edge earlier
    assign wr_fire = psel & penable & pready & pwrite;
    assign wbyte   = pwdata[7:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_enable_q    <= eiu_pkg::RST_REG[eiu_pkg::EXT_W-1:0];
            group_enable_q  <= eiu_pkg::RST_REG[eiu_pkg::GROUP_W-1:0];
            sense_q         <= eiu_pkg::RST_REG[eiu_pkg::SENSE_W-1:0];
            pin_mask_low_q  <= eiu_pkg::RST_REG;
            pin_mask_mid_q  <= eiu_pkg::RST_REG[eiu_pkg::MID_W-1:0];
            pin_mask_high_q <= eiu_pkg::RST_REG;
        end else if (wr_fire) begin
            case (paddr)
                eiu_pkg::OFS_EXT_ENABLE:   ext_enable_q   <= wbyte[eiu_pkg::EXT_W-1:0];
                eiu_pkg::OFS_GROUP_ENABLE: group_enable_q <= wbyte[eiu_pkg::GROUP_W-1:0];
                eiu_pkg::OFS_SENSE_CTRL:   sense_q        <= wbyte[eiu_pkg::SENSE_W-1:0];
                eiu_pkg::OFS_MASK_LOW:     pin_mask_low_q <= wbyte;
                eiu_pkg::OFS_MASK_MID:     pin_mask_mid_q <= wbyte[eiu_pkg::MID_W-1:0];
                eiu_pkg::OFS_MASK_HIGH:    pin_mask_high_q <= wbyte;
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // dedicated pin edge detection

    logic [1:0] sense_code [2];
    logic [1:0] ext_hit;
    logic [1:0] ext_level_mode;
    logic [1:0] ext_low;

    assign sense_code[0] = sense_q[eiu_pkg::SENSE_ZERO_LO +: 2];
    assign sense_code[1] = sense_q[eiu_pkg::SENSE_ONE_LO +: 2];

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ext
            logic rise;
            logic fall;
            assign rise = ext_sync_q[gi] & ~ext_prev_q[gi];
            assign fall = ~ext_sync_q[gi] & ext_prev_q[gi];
            assign ext_low[gi] = ~ext_sync_q[gi];
            assign ext_level_mode[gi] =
                (sense_code[gi] == eiu_pkg::SENSE_LOW_LEVEL);
            always_comb begin
                case (eiu_pkg::eiu_sense_type'(sense_code[gi]))
                    eiu_pkg::SENSE_ANY_EDGE: ext_hit[gi] = rise | fall;
                    eiu_pkg::SENSE_FALLING:  ext_hit[gi] = fall;
                    eiu_pkg::SENSE_RISING:   ext_hit[gi] = rise;
                    default:                 ext_hit[gi] = 1'b0;
                endcase
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // pin flags: set wins over any clear

    logic [1:0] ext_w1c;
    logic [1:0] ext_set;

    assign ext_w1c = (wr_fire && paddr == eiu_pkg::OFS_EXT_FLAGS) ?
                     wbyte[eiu_pkg::EXT_W-1:0] : 2'h0;
    // edges need the io clock; stopped outside idle sleep
    assign ext_set = ext_hit & {2{io_clock_running}};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_flag_q <= eiu_pkg::RST_REG[eiu_pkg::EXT_W-1:0];
        end else begin
            ext_flag_q <= (ext_flag_q & ~ext_w1c & ~ext_irq_serviced
                          | ext_set)
                          & ~ext_level_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin-change groups

    logic [23:0] pc_mask;
    logic [PC_W-1:0] pc_change;
    logic [2:0]  group_hit;
    logic [2:0]  group_w1c;

    // bit 15 has no pin and no mask
    assign pc_mask   = {pin_mask_high_q, 1'b0, pin_mask_mid_q, pin_mask_low_q};
    // no io clock gating here, so it works through sleep
    assign pc_change = (pc_sync_q ^ pc_prev_q) & pc_mask[PC_W-1:0];
    assign group_hit = {|pc_change[23:16], |pc_change[14:8], |pc_change[7:0]};
    assign group_w1c = (wr_fire && paddr == eiu_pkg::OFS_GROUP_FLAGS) ?
                       wbyte[eiu_pkg::GROUP_W-1:0] : 3'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            group_flag_q <= eiu_pkg::RST_REG[eiu_pkg::GROUP_W-1:0];
        end else begin
            group_flag_q <= group_flag_q & ~group_w1c & ~group_irq_serviced
                            | group_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // requests to the cpu and wake-up

    logic [1:0] ext_req_d;

    // level mode requests straight from the pin, as long as it is low
    assign ext_req_d = (ext_level_mode & ext_low | ~ext_level_mode & ext_flag_q)
                       & ext_enable_q & {2{global_irq_enable}};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_irq_request   <= '0;
            group_irq_request <= '0;
            wake_request      <= 1'b0;
        end else begin
            ext_irq_request   <= ext_req_d;
            group_irq_request <= group_flag_q & group_enable_q
                                 & {3{global_irq_enable}};
            // level wake is not gated by io clock; the low must still be sampled at a pclk edge
            wake_request      <= |(ext_level_mode & ext_low & ext_enable_q)
                                 | |(group_hit & group_enable_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb answer: one wait state, then pready for one cycle

    logic [7:0] rd_d;
    logic       hit_d;

    always_comb begin
        rd_d  = 8'h00;
        hit_d = 1'b1;
        case (paddr)
            eiu_pkg::OFS_EXT_FLAGS:    rd_d = {6'h00, ext_flag_q};
            eiu_pkg::OFS_EXT_ENABLE:   rd_d = {6'h00, ext_enable_q};
            eiu_pkg::OFS_GROUP_FLAGS:  rd_d = {5'h00, group_flag_q};
            eiu_pkg::OFS_SENSE_CTRL:   rd_d = {4'h0, sense_q};
            eiu_pkg::OFS_GROUP_ENABLE: rd_d = {5'h00, group_enable_q};
            eiu_pkg::OFS_MASK_LOW:     rd_d = pin_mask_low_q;
            eiu_pkg::OFS_MASK_MID:     rd_d = {1'b0, pin_mask_mid_q};
            eiu_pkg::OFS_MASK_HIGH:    rd_d = pin_mask_high_q;
            default:                   hit_d = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= ~hit_d;
            prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_d};
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
    end

endmodule

/* eiu_pin_src.sv */
// pin sources driving the external interrupt unit
// assumes the bench sets wanted levels just after pclk edges
`timescale 1ns/1ps
module eiu_pin_src (
    // clock
    input  wire logic        pclk,
    // wanted levels, then pins
    input  wire logic [25:0] want,
    output logic      [25:0] pins
);
    // whole-cycle levels: every pulse lasts at least one clock, every low is held
    initial pins = 26'h0;
    always @(posedge pclk) pins <= want;
endmodule

/* eiu_properties.sv */
// port assertions for the external interrupt unit
// assumes one pclk domain and the one-wait-state apb answer
`timescale 1ns/1ps
module eiu_properties (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // pins and cpu side
    input wire logic        ext_irq_pin_zero,
    input wire logic        global_irq_enable,
    input wire logic [1:0]  ext_irq_serviced,
    input wire logic [1:0]  ext_irq_request,
    input wire logic [2:0]  group_irq_request
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic mapped;
    assign mapped = paddr inside {eiu_pkg::OFS_EXT_FLAGS, eiu_pkg::OFS_EXT_ENABLE,
        eiu_pkg::OFS_GROUP_FLAGS, eiu_pkg::OFS_SENSE_CTRL, eiu_pkg::OFS_GROUP_ENABLE,
        eiu_pkg::OFS_MASK_LOW, eiu_pkg::OFS_MASK_MID, eiu_pkg::OFS_MASK_HIGH};
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    // six quiet samples: no edge or level event can still be in flight
    sequence s_pin_quiet;
        ext_irq_pin_zero [*6];
    endsequence
    a_ready_answer: assert property (s_access |=> pready)
        else $error("no answer after access phase");
    a_ready_pulse: assert property (pready |-> s_answer)
        else $error("answer longer than one cycle");
    a_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("data or error outside answer");
    a_error_map: assert property (pready |-> pslverr == !mapped)
        else $error("error response disagrees with map");
    a_upper_zero: assert property (
        pready && !pwrite |-> prdata[31:8] == 24'h0 && !(paddr == eiu_pkg::OFS_MASK_MID && prdata[7]))
        else $error("unused read bits not zero");
    a_ext_global: assert property (|ext_irq_request |-> $past(global_irq_enable))
        else $error("pin request without global flag");
    a_group_global: assert property (|group_irq_request |-> $past(global_irq_enable))
        else $error("group request without global flag");
    a_service_clear: assert property (
        s_pin_quiet ##0 ext_irq_serviced[0] |=> ##1 !ext_irq_request[0])
        else $error("service left pin request standing");
endmodule

bind eiu_top eiu_properties i_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
    .pready, .pslverr, .ext_irq_pin_zero, .global_irq_enable, .ext_irq_serviced,
    .ext_irq_request, .group_irq_request);

/* tb.sv */
// self-checking bench for the external interrupt unit
// assumes eiu_pkg, the pin source model and the checker are compiled first
`timescale 1ns/1ps
module tb;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er, gie = 0;
    logic        iorun = 1, pready, pslverr, wake;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, tg, rnd = 32'h45409FD3;
    logic [1:0]  ext_srv = 2'h0, ext_req;
    logic [2:0]  grp_srv = 3'h0, grp_req;
    logic [25:0] want = 26'h0, pins;
    int          fails = 0, total_checks = 0, cyc = 0, exp;
    logic [7:0]  adr [8] = '{eiu_pkg::OFS_EXT_FLAGS, eiu_pkg::OFS_EXT_ENABLE,
        eiu_pkg::OFS_GROUP_FLAGS, eiu_pkg::OFS_SENSE_CTRL, eiu_pkg::OFS_GROUP_ENABLE,
        eiu_pkg::OFS_MASK_LOW, eiu_pkg::OFS_MASK_MID, eiu_pkg::OFS_MASK_HIGH};
    // readback masks; flags read zero after a write of ones
    int          wmask [8] = '{0, 3, 0, 15, 7, 255, 127, 255};

    eiu_pin_src i_src (.pclk, .want, .pins);
    eiu_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .ext_irq_pin_zero(pins[24]), .ext_irq_pin_one(pins[25]),
        .pin_change_inputs(pins[23:0]), .global_irq_enable(gie), .io_clock_running(iorun),
        .ext_irq_serviced(ext_srv), .group_irq_serviced(grp_srv), .ext_irq_request(ext_req),
        .group_irq_request(grp_req), .wake_request(wake));
    ////////////////////////////////////////////////////////////////////////////////
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            summarize();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] ev);
        total_checks++;
        if (got !== ev) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, ev);
        end
    endtask
    // holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rdchk(input logic [7:0] a, input int e);
        apb(0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        for (int i = 0; i < 8; i++) rdchk(adr[i], 0);
        apb(0, 8'h40, 32'h0);
        chk(er, 1);
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            apb(1, adr[i], rnd);
            rdchk(adr[i], rnd & wmask[i]);
        end
        $display("test registers done");
        gie <= 1;
        for (int p = 0; p < 2; p++) begin
            apb(1, adr[1], 1 << p);
            for (int m = 1; m < 4; m++) begin
                apb(1, adr[3], m << (2 * p));
                want[24 + p] <= 1;
                wt(8);
                exp = (m != 2) << p;
                rdchk(adr[0], exp);
                chk(ext_req, exp);
                ext_srv <= 2'(1 << p);
                wt(1);
                ext_srv <= 2'h0;
                wt(3);
                chk(ext_req, 0);
                want[24 + p] <= 0;
                wt(8);
                rdchk(adr[0], (m < 3) << p);
                apb(1, adr[0], 32'h3);
                rdchk(adr[0], 0);
            end
            // level mode: request follows the low pin, flag stays clear
            apb(1, adr[3], 32'h0);
            wt(5);
            chk(ext_req, 1 << p);
            rdchk(adr[0], 0);
            gie <= 0;
            wt(3);
            chk(ext_req, 0);
            chk(wake, 1);
            want[24 + p] <= 1;
            gie <= 1;
            wt(8);
            chk(wake, 0);
        end
        $display("test pins done");
        apb(1, adr[3], 32'h2);
        apb(1, adr[1], 32'h1);
        iorun <= 0;
        want[24] <= 0;
        wt(8);
        rdchk(adr[0], 0);
        chk(ext_req, 0);
        iorun <= 1;
        $display("test sleep done");
        apb(1, adr[4], 32'h7);
        for (int k = 0; k < 6; k++) begin
            rnd = lfsr(rnd);
            for (int j = 0; j < 3; j++) apb(1, adr[5 + j], rnd >> (8 * j));
            tg = lfsr(rnd);
            iorun <= k[0];
            want[23:0] <= want[23:0] ^ tg[23:0];
            wt(8);
            exp = {|(tg[23:16] & rnd[23:16]), |(tg[14:8] & rnd[14:8]), |(tg[7:0] & rnd[7:0])};
            rdchk(adr[2], exp);
            chk(grp_req, exp);
            if (k[0]) apb(1, adr[2], 32'h7);
            else begin
                grp_srv <= 3'h7;
                wt(1);
                grp_srv <= 3'h0;
                wt(3);
            end
            rdchk(adr[2], 0);
            rnd = tg;
        end
        $display("test groups done");
        summarize();
    end
endmodule
